//--- oad_decoder.sv
// Operand addressing byte and protection-control opcode decoder
module oad_decoder (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   byte_valid_i,
  input  wire logic [7:0]             byte_i,
  input  wire logic                   modrm_next_i,
  input  wire logic                   protected_mode_i,
  input  wire oad_pkg::oad_regs_type  regs_i,
  output logic                        result_valid_o,
  output oad_pkg::oad_result_type     result_o
);

  oad_pkg::oad_state_type  state;
  oad_pkg::oad_state_type  next_state;
  oad_pkg::oad_result_type next_result;
  logic [7:0]              opc;
  logic                    two_byte;
  logic [7:0]              modrm;
  logic [7:0]              next_modrm;
  logic [7:0]              disp_lo;
  logic [15:0]             next_disp;
  logic                    ovr_valid;
  oad_pkg::oad_seg_type    ovr_seg;
  logic                    finish;
  logic                    string_hit;
  logic                    is_prefix;
  logic                    is_string;
  logic                    clear_ovr;

  function automatic oad_pkg::oad_reg_type reg_decode(input logic w, input logic [2:0] code);
    reg_decode = oad_pkg::oad_reg_type'({~w, code});
  endfunction : reg_decode

  function automatic logic [15:0] reg_base(input logic [2:0] rm, input oad_pkg::oad_regs_type r);
    unique case (rm)
      3'b000: reg_base = r.general_base + r.source_index;
      3'b001: reg_base = r.general_base + r.destination_index;
      3'b010: reg_base = r.frame_base + r.source_index;
      3'b011: reg_base = r.frame_base + r.destination_index;
      3'b100: reg_base = r.source_index;
      3'b101: reg_base = r.destination_index;
      3'b110: reg_base = r.frame_base;
      3'b111: reg_base = r.general_base;
    endcase
  endfunction : reg_base

  function automatic oad_pkg::oad_op_type op_decode(input logic tb, input logic [7:0] o,
                                                     input logic [2:0] f);
    op_decode = oad_pkg::no_system_op;
    if (!tb)
    begin
      if (o == oad_pkg::OPC_ADJ_PRIV)
        op_decode = oad_pkg::adjust_privilege_op;
    end
    else
    begin
      unique case (o)
        oad_pkg::OPC_GRP_TABLE:
          unique case (f)
            3'b000: op_decode = oad_pkg::store_local_table_op;
            3'b001: op_decode = oad_pkg::store_task_reg_op;
            3'b010: op_decode = oad_pkg::load_local_table_op;
            3'b011: op_decode = oad_pkg::load_task_reg_op;
            3'b100: op_decode = oad_pkg::verify_access_op;
            3'b101: op_decode = oad_pkg::verify_write_op;
            default: op_decode = oad_pkg::no_system_op;
          endcase
        oad_pkg::OPC_GRP_SYS:
          unique case (f)
            3'b000: op_decode = oad_pkg::store_global_table_op;
            3'b001: op_decode = oad_pkg::store_interrupt_table_op;
            3'b010: op_decode = oad_pkg::load_global_table_op;
            3'b011: op_decode = oad_pkg::load_interrupt_table_op;
            3'b100: op_decode = oad_pkg::store_machine_word_op;
            3'b110: op_decode = oad_pkg::load_machine_word_op;
            default: op_decode = oad_pkg::no_system_op;
          endcase
        oad_pkg::OPC_ACC_RIGHT: op_decode = oad_pkg::load_access_rights_op;
        oad_pkg::OPC_SEG_LIMIT: op_decode = oad_pkg::load_segment_limit_op;
        default: op_decode = oad_pkg::no_system_op;
      endcase
    end
  endfunction : op_decode

  // Returns {allowed in current mode, clock count}
  function automatic logic [5:0] op_clocks(input oad_pkg::oad_op_type op, input logic rf,
                                           input logic prot);
    op_clocks = {1'b1, 5'h00};
    unique case (op)
      oad_pkg::load_global_table_op,
      oad_pkg::store_global_table_op:
        op_clocks = {1'b1, oad_pkg::CLK_GDT};
      oad_pkg::load_interrupt_table_op,
      oad_pkg::store_interrupt_table_op:
        op_clocks = {1'b1, oad_pkg::CLK_IDT};
      oad_pkg::load_local_table_op,
      oad_pkg::load_task_reg_op:
        op_clocks = {prot, rf ? oad_pkg::CLK_TBL_LD_R : oad_pkg::CLK_TBL_LD_M};
      oad_pkg::store_local_table_op,
      oad_pkg::store_task_reg_op:
        op_clocks = {prot, rf ? oad_pkg::CLK_STORE_R : oad_pkg::CLK_STORE_M};
      oad_pkg::load_machine_word_op:
        op_clocks = {1'b1, rf ? oad_pkg::CLK_MSW_LD_R : oad_pkg::CLK_MSW_LD_M};
      oad_pkg::store_machine_word_op:
        op_clocks = {1'b1, rf ? oad_pkg::CLK_STORE_R : oad_pkg::CLK_STORE_M};
      oad_pkg::load_access_rights_op,
      oad_pkg::load_segment_limit_op,
      oad_pkg::verify_access_op,
      oad_pkg::verify_write_op:
        op_clocks = {prot, rf ? oad_pkg::CLK_CHECK_R : oad_pkg::CLK_CHECK_M};
      oad_pkg::adjust_privilege_op:
        op_clocks = {prot, rf ? oad_pkg::CLK_ADJ_R : oad_pkg::CLK_ADJ_M};
      oad_pkg::no_system_op:
        op_clocks = {1'b1, 5'h00};
    endcase
  endfunction : op_clocks

  assign is_prefix = (byte_i & oad_pkg::PFX_SEG_MASK) == oad_pkg::PFX_SEG_MATCH;
  // String ops that access memory through the destination index
  assign is_string = (byte_i[7:4] == oad_pkg::STRING_NIBBLE)
                   && ((byte_i[2] && !byte_i[3]) || (byte_i[1] && byte_i[3]));

  always_comb
  begin
    next_state = state;
    next_modrm = modrm;
    next_disp  = 16'h0000;
    finish     = 1'b0;
    string_hit = 1'b0;
    unique case (state)
      oad_pkg::ST_OPCODE:
        if (byte_valid_i && !is_prefix)
        begin
          if (byte_i == oad_pkg::OPC_TWO_BYTE)
            next_state = oad_pkg::ST_EXT;
          else if (byte_i == oad_pkg::OPC_ADJ_PRIV || modrm_next_i)
            next_state = oad_pkg::ST_MODRM;
          else if (is_string)
            string_hit = 1'b1;
        end
      oad_pkg::ST_EXT:
        if (byte_valid_i)
        begin
          if (byte_i inside {oad_pkg::OPC_GRP_TABLE, oad_pkg::OPC_GRP_SYS,
                             oad_pkg::OPC_ACC_RIGHT, oad_pkg::OPC_SEG_LIMIT})
            next_state = oad_pkg::ST_MODRM;
          else
            next_state = oad_pkg::ST_OPCODE;
        end
      oad_pkg::ST_MODRM:
        if (byte_valid_i)
        begin
          next_modrm = byte_i;
          if (byte_i[7:6] == oad_pkg::MOD_REG
              || (byte_i[7:6] == oad_pkg::MOD_NONE && byte_i[2:0] != oad_pkg::RM_DIRECT))
          begin
            finish     = 1'b1;
            next_state = oad_pkg::ST_OPCODE;
          end
          else
            next_state = oad_pkg::ST_DISP_LO;
        end
      oad_pkg::ST_DISP_LO:
        if (byte_valid_i)
        begin
          if (modrm[7:6] == oad_pkg::MOD_D8)
          begin
            next_disp  = {{8{byte_i[7]}}, byte_i};
            finish     = 1'b1;
            next_state = oad_pkg::ST_OPCODE;
          end
          else
            next_state = oad_pkg::ST_DISP_HI;
        end
      oad_pkg::ST_DISP_HI:
        if (byte_valid_i)
        begin
          // Second byte is the upper half
          next_disp  = {byte_i, disp_lo};
          finish     = 1'b1;
          next_state = oad_pkg::ST_OPCODE;
        end
      default:
        next_state = oad_pkg::ST_OPCODE;
    endcase
  end

  assign clear_ovr = byte_valid_i && next_state == oad_pkg::ST_OPCODE
                   && !(state == oad_pkg::ST_OPCODE && is_prefix);

  always_comb
  begin
    logic       direct;
    logic [5:0] ck;
    direct = 1'b0;
    ck     = 6'h00;
    next_result = '0;
    if (string_hit)
    begin
      next_result.string_dest       = 1'b1;
      next_result.segment           = oad_pkg::extra_segment;
      next_result.effective_address = regs_i.destination_index;
      next_result.wide              = byte_i[0];
      next_result.mode_ok           = 1'b1;
    end
    else
    begin
      direct = next_modrm[7:6] == oad_pkg::MOD_NONE && next_modrm[2:0] == oad_pkg::RM_DIRECT;
      next_result.op     = op_decode(two_byte, opc, next_modrm[5:3]);
      next_result.mode   = next_modrm[7:6];
      next_result.wide   = two_byte | opc[0];
      next_result.is_reg = next_modrm[7:6] == oad_pkg::MOD_REG;
      next_result.rm_reg    = reg_decode(next_result.wide, next_modrm[2:0]);
      next_result.field_reg = reg_decode(next_result.wide, next_modrm[5:3]);
      if (direct)
        next_result.effective_address = next_disp;
      else if (!next_result.is_reg)
        next_result.effective_address = reg_base(next_modrm[2:0], regs_i) + next_disp;
      next_result.frame_based = !direct && !next_result.is_reg
                              && next_modrm[2:0] inside {3'b010, 3'b011, 3'b110};
      next_result.overridden = ovr_valid;
      if (ovr_valid)
        next_result.segment = ovr_seg;
      else if (next_result.frame_based)
        next_result.segment = oad_pkg::stack_segment;
      else
        next_result.segment = oad_pkg::data_segment;
      ck = op_clocks(next_result.op, next_result.is_reg, protected_mode_i);
      next_result.mode_ok = ck[5];
      next_result.clocks  = ck[4:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      state <= oad_pkg::ST_OPCODE;
    else
      state <= next_state;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      opc      <= 8'h00;
      two_byte <= 1'b0;
      modrm    <= 8'h00;
      disp_lo  <= 8'h00;
    end
    else if (byte_valid_i)
    begin
      if (state == oad_pkg::ST_OPCODE && !is_prefix)
      begin
        opc      <= byte_i;
        two_byte <= 1'b0;
      end
      else if (state == oad_pkg::ST_EXT)
      begin
        opc      <= byte_i;
        two_byte <= 1'b1;
      end
      modrm <= next_modrm;
      if (state == oad_pkg::ST_DISP_LO)
        disp_lo <= byte_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ovr_valid <= 1'b0;
      ovr_seg   <= oad_pkg::data_segment;
    end
    else if (state == oad_pkg::ST_OPCODE && byte_valid_i && is_prefix)
    begin
      ovr_valid <= 1'b1;
      ovr_seg   <= oad_pkg::oad_seg_type'(byte_i[oad_pkg::PFX_SEG_LSB +: 2]);
    end
    else if (clear_ovr)
      ovr_valid <= 1'b0;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      result_valid_o <= 1'b0;
      result_o       <= '0;
    end
    else
    begin
      result_valid_o <= finish | string_hit;
      if (finish | string_hit)
        result_o <= next_result;
    end
  end

  logic [15:0] base_now;
  logic [15:0] base_held;
  logic        take_modrm;
  assign base_now   = reg_base(byte_i[2:0], regs_i);
  assign base_held  = reg_base(modrm[2:0], regs_i);
  assign take_modrm = state == oad_pkg::ST_MODRM && byte_valid_i;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_REG_FORM: assert property (take_modrm && byte_i[7:6] == oad_pkg::MOD_REG
    |=> result_valid_o && result_o.is_reg && result_o.rm_reg == reg_decode(result_o.wide, $past(byte_i[2:0])))
    else $error("register form not decoded");
  AST_NO_DISP: assert property (take_modrm && byte_i[7:6] == oad_pkg::MOD_NONE
    && byte_i[2:0] != oad_pkg::RM_DIRECT |=> result_valid_o && result_o.effective_address == $past(base_now))
    else $error("mode 00 address wrong");
  AST_DISP8: assert property (state == oad_pkg::ST_DISP_LO && byte_valid_i
    && modrm[7:6] == oad_pkg::MOD_D8 |=> result_valid_o
    && result_o.effective_address == $past(base_held) + {{8{$past(byte_i[7])}}, $past(byte_i)})
    else $error("short displacement wrong");
  AST_DISP16: assert property (take_modrm && byte_i[7:6] == oad_pkg::MOD_D16
    |=> !result_valid_o && state == oad_pkg::ST_DISP_LO)
    else $error("long displacement ended early");
  AST_DIRECT: assert property (state == oad_pkg::ST_DISP_HI && byte_valid_i
    && modrm[7:6] == oad_pkg::MOD_NONE |=> result_o.effective_address == {$past(byte_i), $past(disp_lo)}
    && !result_o.frame_based)
    else $error("direct address wrong");
  AST_FRAME_SEG: assert property (result_valid_o && result_o.frame_based
    && !result_o.overridden |-> result_o.segment == oad_pkg::stack_segment)
    else $error("frame base not on stack segment");
  AST_OVR_SEG: assert property (result_valid_o && result_o.overridden
    |-> result_o.segment == $past(ovr_seg))
    else $error("override segment not applied");
  AST_STRING_ES: assert property (result_valid_o && result_o.string_dest
    |-> result_o.segment == oad_pkg::extra_segment)
    else $error("string destination not extra segment");
  AST_DATA_SEG: assert property (result_valid_o && !result_o.frame_based && !result_o.is_reg
    && !result_o.string_dest && !result_o.overridden |-> result_o.segment == oad_pkg::data_segment)
    else $error("default segment not data");
  AST_GDT_CLK: assert property (result_valid_o
    && result_o.op inside {oad_pkg::load_global_table_op, oad_pkg::store_global_table_op}
    |-> result_o.clocks == 5'h0b && result_o.mode_ok)
    else $error("global table clocks wrong");
  AST_ADJ_CLK: assert property (result_valid_o && result_o.op == oad_pkg::adjust_privilege_op
    |-> result_o.mode_ok == $past(protected_mode_i) && result_o.clocks == (result_o.is_reg ? 5'h0a : 5'h0b))
    else $error("adjust privilege decode wrong");

  COV_DIRECT: cover property (state == oad_pkg::ST_DISP_HI && modrm[7:6] == oad_pkg::MOD_NONE
    && byte_valid_i ##1 result_valid_o);
  COV_STRING: cover property (result_valid_o && result_o.string_dest && $past(ovr_valid));
  COV_LOAD_GDT: cover property (result_valid_o && result_o.op == oad_pkg::load_global_table_op);
endmodule : oad_decoder

//--- oad_pkg.sv
// Types and constants for the operand address decoder
package oad_pkg;
  localparam logic [7:0] OPC_TWO_BYTE  = 8'h0f;
  localparam logic [7:0] OPC_GRP_TABLE = 8'h00;
  localparam logic [7:0] OPC_GRP_SYS   = 8'h01;
  localparam logic [7:0] OPC_ACC_RIGHT = 8'h02;
  localparam logic [7:0] OPC_SEG_LIMIT = 8'h03;
  localparam logic [7:0] OPC_ADJ_PRIV  = 8'h63;
  localparam logic [7:0] PFX_SEG_MASK  = 8'he7;
  localparam logic [7:0] PFX_SEG_MATCH = 8'h26;
  localparam logic [3:0] STRING_NIBBLE = 4'ha;
  localparam int         PFX_SEG_LSB   = 3;
  localparam logic [1:0] MOD_NONE      = 2'h0;
  localparam logic [1:0] MOD_D8        = 2'h1;
  localparam logic [1:0] MOD_D16       = 2'h2;
  localparam logic [1:0] MOD_REG       = 2'h3;
  localparam logic [2:0] RM_DIRECT     = 3'h6;
  localparam logic [4:0] CLK_GDT       = 5'h0b;
  localparam logic [4:0] CLK_IDT       = 5'h0c;
  localparam logic [4:0] CLK_TBL_LD_R  = 5'h11;
  localparam logic [4:0] CLK_TBL_LD_M  = 5'h13;
  localparam logic [4:0] CLK_STORE_R   = 5'h02;
  localparam logic [4:0] CLK_STORE_M   = 5'h03;
  localparam logic [4:0] CLK_MSW_LD_R  = 5'h03;
  localparam logic [4:0] CLK_MSW_LD_M  = 5'h06;
  localparam logic [4:0] CLK_CHECK_R   = 5'h0e;
  localparam logic [4:0] CLK_CHECK_M   = 5'h10;
  localparam logic [4:0] CLK_ADJ_R     = 5'h0a;
  localparam logic [4:0] CLK_ADJ_M     = 5'h0b;

  typedef enum logic [1:0] {
    extra_segment = 2'b00,
    code_segment  = 2'b01,
    stack_segment = 2'b10,
    data_segment  = 2'b11
  } oad_seg_type;

  typedef enum logic [3:0] {
    accumulator_word       = 4'b0000,
    count_word             = 4'b0001,
    data_word_register     = 4'b0010,
    general_base_word      = 4'b0011,
    stack_pointer_word     = 4'b0100,
    frame_base_word        = 4'b0101,
    source_index_word      = 4'b0110,
    destination_index_word = 4'b0111,
    accumulator_low_byte   = 4'b1000,
    count_low_byte         = 4'b1001,
    data_low_byte          = 4'b1010,
    general_base_low_byte  = 4'b1011,
    accumulator_high_byte  = 4'b1100,
    count_high_byte        = 4'b1101,
    data_high_byte         = 4'b1110,
    general_base_high_byte = 4'b1111
  } oad_reg_type;

  typedef enum logic [3:0] {
    no_system_op             = 4'b0000,
    load_global_table_op     = 4'b0001,
    store_global_table_op    = 4'b0010,
    load_interrupt_table_op  = 4'b0011,
    store_interrupt_table_op = 4'b0100,
    load_local_table_op      = 4'b0101,
    store_local_table_op     = 4'b0110,
    load_task_reg_op         = 4'b0111,
    store_task_reg_op        = 4'b1000,
    load_machine_word_op     = 4'b1001,
    store_machine_word_op    = 4'b1010,
    load_access_rights_op    = 4'b1011,
    load_segment_limit_op    = 4'b1100,
    verify_access_op         = 4'b1101,
    verify_write_op          = 4'b1110,
    adjust_privilege_op      = 4'b1111
  } oad_op_type;

  typedef enum logic [2:0] {
    ST_OPCODE  = 3'b000,
    ST_EXT     = 3'b001,
    ST_MODRM   = 3'b010,
    ST_DISP_LO = 3'b011,
    ST_DISP_HI = 3'b100
  } oad_state_type;

  typedef struct packed {
    logic [15:0] general_base;
    logic [15:0] frame_base;
    logic [15:0] source_index;
    logic [15:0] destination_index;
  } oad_regs_type;

  typedef struct packed {
    oad_op_type  op;
    logic [15:0] effective_address;
    oad_seg_type segment;
    logic [1:0]  mode;
    logic        is_reg;
    logic        wide;
    oad_reg_type rm_reg;
    oad_reg_type field_reg;
    logic        frame_based;
    logic        overridden;
    logic        string_dest;
    logic [4:0]  clocks;
    logic        mode_ok;
  } oad_result_type;
endpackage : oad_pkg

//--- oad_fetch_model.sv
// Fetch path model streaming instruction bytes into the decoder
module oad_fetch_model (
  input  wire logic  clk_i,
  output logic       valid_o,
  output logic [7:0] byte_o,
  output logic       modrm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] q[$];
  int         gap;
  int         idle_cnt;

  initial
  begin
    valid_o  = 1'b0;
    byte_o   = 8'h00;
    modrm_o  = 1'b0;
    gap      = 0;
    idle_cnt = 0;
  end

  task automatic push(input logic [8:0] e);
    q.push_back(e);
  endtask : push

  always @(negedge clk_i)
  begin
    if (q.size() != 0 && idle_cnt >= gap)
    begin
      {modrm_o, byte_o} = q.pop_front();
      valid_o = 1'b1;
      idle_cnt = 0;
    end
    else
    begin
      // Released lines change every cycle
      byte_o = ~byte_o;
      modrm_o = ~modrm_o;
      valid_o = 1'b0;
      idle_cnt++;
    end
  end
endmodule : oad_fetch_model

//--- operand_address_and_system_op_decode_tb.sv
// Self-checking testbench for the operand address decoder
module operand_address_and_system_op_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] GB = 16'h1200;
  localparam logic [15:0] FB = 16'h3400;
  localparam logic [15:0] SI = 16'h0056;
  localparam logic [15:0] DI = 16'h0780;
  logic                    core_clk_i;
  logic                    rst_i;
  logic                    byte_valid_i;
  logic [7:0]              byte_i;
  logic                    modrm_next_i;
  logic                    protected_mode_i;
  oad_pkg::oad_regs_type   regs_i;
  logic                    result_valid_o;
  oad_pkg::oad_result_type result_o;
  int                      mismatches;
  int                      tests_run;
  int                      cycles;
  logic [33:0]             tb[15];

  oad_decoder dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i),
    .modrm_next_i(modrm_next_i), .protected_mode_i(protected_mode_i), .regs_i(regs_i),
    .result_valid_o(result_valid_o), .result_o(result_o));
  oad_fetch_model fetch_u (.clk_i(core_clk_i), .valid_o(byte_valid_i), .byte_o(byte_i), .modrm_o(modrm_next_i));

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic tally_and_finish;
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic put(input logic [7:0] b, input logic m);
    fetch_u.push({m, b});
  endtask : put

  task automatic wait_res;
    int n;
    n = 0;
    @(negedge core_clk_i);
    while (result_valid_o !== 1'b1 && n < 60)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk(16'(n < 60), 16'h1);
  endtask : wait_res

  function automatic logic [15:0] ea_of(input logic [2:0] rm, input logic [15:0] d);
    logic [15:0] t[8];
    t = '{GB + SI, GB + DI, FB + SI, FB + DI, SI, DI, FB, GB};
    return t[rm] + d;
  endfunction : ea_of

  task automatic t_walk;
    fetch_u.gap = 2;
    protected_mode_i = 1'b1;
    put(8'h0f, 1'b0); put(8'h01, 1'b0); put(8'h92, 1'b0); put(8'h34, 1'b0); put(8'h12, 1'b0);
    wait_res();
    chk(16'(result_o.op), 16'(oad_pkg::load_global_table_op));
    chk(16'(result_o.clocks), 16'd11);
    chk(result_o.effective_address, FB + SI + 16'h1234);
    chk(16'(result_o.segment), 16'(oad_pkg::stack_segment));
    fetch_u.gap = 0;
  endtask : t_walk

  task automatic t_ea;
    for (int rm = 0; rm < 8; rm++)
    begin
      put(8'h8b, 1'b1); put({5'b01000, 3'(rm)}, 1'b0); put(8'hf0, 1'b0);
      wait_res();
      chk(result_o.effective_address, ea_of(3'(rm), 16'hfff0));
      chk(16'(result_o.segment), (rm == 2 || rm == 3 || rm == 6) ? 16'h2 : 16'h3);
    end
    put(8'h8b, 1'b1); put(8'h06, 1'b0); put(8'h78, 1'b0); put(8'h56, 1'b0);
    wait_res();
    chk(result_o.effective_address, 16'h5678);
    put(8'h8b, 1'b1); put(8'h00, 1'b0); put(8'h8b, 1'b1); put(8'h07, 1'b0);
    wait_res();
    chk(result_o.effective_address, GB + SI);
    wait_res();
    chk(result_o.effective_address, GB);
  endtask : t_ea

  task automatic t_regs;
    for (int k = 0; k < 16; k++)
    begin
      put({7'b1000101, 1'(k >> 3)}, 1'b1); put({5'b11101, 3'(k)}, 1'b0);
      wait_res();
      chk(16'(result_o.is_reg), 16'h1);
      chk(16'(result_o.rm_reg), {12'h0, ~1'(k >> 3), 3'(k)});
      chk(16'(result_o.field_reg), {12'h0, ~1'(k >> 3), 3'b101});
    end
  endtask : t_regs

  task automatic t_override;
    for (int c = 0; c < 4; c++)
    begin
      put(8'h26 | 8'(c << 3), 1'b0); put(8'h8b, 1'b1); put(8'h46, 1'b0); put(8'h00, 1'b0);
      wait_res();
      chk(16'(result_o.segment), 16'(c));
    end
    put(8'h2e, 1'b0); put(8'ha5, 1'b0);
    wait_res();
    chk(16'(result_o.segment), 16'(oad_pkg::extra_segment));
    chk(result_o.effective_address, DI);
  endtask : t_override

  task automatic t_sys;
    tb = '{{24'h0f0117, 4'h1, 5'd11, 1'b0}, {24'h0f0107, 4'h2, 5'd11, 1'b0}, {24'h0f011f, 4'h3, 5'd12, 1'b0},
           {24'h0f01cf, 4'h4, 5'd12, 1'b0}, {24'h0f00d0, 4'h5, 5'd17, 1'b1}, {24'h0f0007, 4'h6, 5'd3, 1'b1},
           {24'h0f001f, 4'h7, 5'd19, 1'b1}, {24'h0f00c8, 4'h8, 5'd2, 1'b1}, {24'h0f01f0, 4'h9, 5'd3, 1'b0},
           {24'h0f0127, 4'ha, 5'd3, 1'b0}, {24'h0f02c0, 4'hb, 5'd14, 1'b1}, {24'h0f0307, 4'hc, 5'd16, 1'b1},
           {24'h0f00e0, 4'hd, 5'd14, 1'b1}, {24'h0f002f, 4'he, 5'd16, 1'b1}, {24'h63c0ff, 4'hf, 5'd10, 1'b1}};
    for (int p = 0; p < 2; p++)
    begin
      protected_mode_i = 1'(p);
      foreach (tb[i])
      begin
        put(tb[i][33:26], 1'b1);
        put(tb[i][25:18], 1'b0);
        if (tb[i][33:26] == 8'h0f)
          put(tb[i][17:10], 1'b0);
        wait_res();
        chk(16'(result_o.op), 16'(tb[i][9:6]));
        chk(16'(result_o.clocks), 16'(tb[i][5:1]));
        chk(16'(result_o.mode_ok), 16'(p == 1 || !tb[i][0]));
      end
    end
  endtask : t_sys

  initial
  begin
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    rst_i = 1'b1;
    protected_mode_i = 1'b0;
    regs_i = '{general_base: GB, frame_base: FB, source_index: SI, destination_index: DI};
    repeat (6) @(negedge core_clk_i);
    chk(16'(result_valid_o), 16'h0);
    rst_i = 1'b0;
    t_walk();
    t_ea();
    t_regs();
    t_override();
    t_sys();
    tally_and_finish();
  end
endmodule : operand_address_and_system_op_decode_tb
